// file: logic/uci_core_status.sv
// Core interrupt status and mask registers with event capture and summaries
`timescale 1ns/1ps
`include "uci_defs.svh"
module uci_core_status #(
	parameter int IDLE_CYC = `UCI_IDLE_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_soft_rst,
	input wire logic i_host_mode,
	input wire logic i_dma_mode,
	input wire logic i_fs_mode,
	input wire logic i_tx_empty_level_select,
	input wire logic i_line_active,
	input wire logic [1:0] i_enum_speed,
	input wire uci_pkg::uci_evt_s i_evt,
	input wire uci_pkg::uci_lvl_s i_lvl,
	input wire logic i_reg_rd,
	input wire logic i_reg_wr,
	input wire logic [`UCI_ADDR_W-1:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	output logic [31:0] o_reg_rdata,
	output logic o_reg_rvalid,
	output logic [31:0] o_status,
	output logic [1:0] o_enum_speed,
	output logic o_iso_drop,
	output logic o_suspended,
	output logic o_irq
);
	uci_pkg::uci_state_s st;
	uci_pkg::uci_state_s next_st;
	logic idle_hit;
	logic periph;
	logic nptx_empty;
	logic [31:0] live;
	logic [31:0] sts;
	logic wr_sts;
	logic wr_msk;
	logic rd_sts;
	logic rd_msk;

	//------------------------------------------------------------
	// Idle detection
	//------------------------------------------------------------
	uci_idle_timer #(
		.IDLE_CYC(IDLE_CYC)
	) u_idle (
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.i_enable(periph),
		.i_line_active(i_line_active),
		.o_idle_hit(idle_hit),
		.o_suspended(o_suspended)
	);

	//------------------------------------------------------------
	// Live level bits
	//------------------------------------------------------------
	assign periph = !i_host_mode;
	// Level select high asks for a fully empty FIFO, low for half empty
	assign nptx_empty = i_host_mode && i_lvl.nptx_queue_free &&
		(i_tx_empty_level_select ? i_lvl.nptx_all_empty : i_lvl.nptx_half_empty);

	always_comb begin
		live = '0;
		live[`UCI_B_HC] = i_host_mode && i_lvl.host_channel_any;
		live[`UCI_B_PORT] = i_host_mode && i_lvl.host_port_any;
		live[`UCI_B_OEP] = periph && i_lvl.out_endpoint_any;
		live[`UCI_B_IEP] = periph && i_lvl.in_endpoint_any;
		live[`UCI_B_NPTX] = nptx_empty;
		live[`UCI_B_RXP] = i_lvl.rx_packet_pending;
		live[`UCI_B_OTG] = i_lvl.dual_role_any;
		live[`UCI_B_ROLE] = i_host_mode;
	end

	assign sts = st.flags | live;

	//------------------------------------------------------------
	// Register decode
	//------------------------------------------------------------
	assign wr_sts = i_reg_wr && (i_reg_addr == `UCI_STS_OFS);
	assign wr_msk = i_reg_wr && (i_reg_addr == `UCI_MSK_OFS);
	assign rd_sts = i_reg_rd && (i_reg_addr == `UCI_STS_OFS);
	assign rd_msk = i_reg_rd && (i_reg_addr == `UCI_MSK_OFS);

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	always_comb begin
		logic [31:0] set;
		set = '0;
		next_st = st;
		next_st.rvalid = i_reg_rd;
		// Unmapped reads answer zero
		next_st.rdata = rd_sts ? sts : (rd_msk ? st.mask : '0);
		if (i_host_mode) begin
			set[`UCI_B_PINC] = i_evt.periodic_incomplete_host;
			set[`UCI_B_SOF] = i_evt.sof_sent;
		end else begin
			set[`UCI_B_FETCH] = i_dma_mode && i_evt.fetch_stall;
			set[`UCI_B_PERIODIC_FRAME_END] = i_evt.periodic_frame_end;
			set[`UCI_B_PINC] = i_evt.periodic_frame_end && i_evt.iso_out_pending;
			set[`UCI_B_IISO] = i_evt.periodic_frame_end && i_evt.iso_in_pending;
			set[`UCI_B_DROP] = o_iso_drop;
			set[`UCI_B_ENUM] = i_evt.speed_enum_done;
			set[`UCI_B_RST] = i_evt.bus_reset_seen;
			set[`UCI_B_SUSP] = idle_hit;
			set[`UCI_B_EARLY_IDLE_SEEN] = idle_hit;
			set[`UCI_B_SOF] = i_fs_mode && i_evt.sof_rcvd;
		end
		// Mismatched accesses are flagged here; the access itself is dropped upstream
		set[`UCI_B_WRONG_MODE_ACCESS] = (i_evt.host_reg_access && periph) ||
			(i_evt.periph_reg_access && i_host_mode);
		// NAK requests take effect one cycle after they are sampled
		set[`UCI_B_ONAK] = st.onak_req;
		set[`UCI_B_INAK] = st.inak_req;
		if (i_evt.set_out_nak_all) begin
			next_st.onak_req = 1'b1;
		end else if (st.onak_req) begin
			next_st.onak_req = 1'b0;
		end
		if (i_evt.set_in_nak_all) begin
			next_st.inak_req = 1'b1;
		end else if (st.inak_req) begin
			next_st.inak_req = 1'b0;
		end
		if (i_evt.speed_enum_done && periph) begin
			next_st.speed = i_enum_speed;
		end
		if (wr_sts) begin
			next_st.flags = st.flags & ~(i_reg_wdata & `UCI_STS_W1C);
		end
		if (i_evt.clear_out_nak_all) begin
			next_st.flags[`UCI_B_ONAK] = 1'b0;
		end
		if (i_evt.clear_in_nak_all) begin
			next_st.flags[`UCI_B_INAK] = 1'b0;
		end
		// A new event in the clearing cycle survives the clear
		next_st.flags = next_st.flags | set;
		if (wr_msk) begin
			next_st.mask = i_reg_wdata & `UCI_MSK_WR;
		end
		if (i_soft_rst) begin
			next_st.flags = '0;
			next_st.mask = '0;
			next_st.onak_req = 1'b0;
			next_st.inak_req = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	//------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------
	assign o_reg_rdata = st.rdata;
	assign o_reg_rvalid = st.rvalid;
	assign o_status = sts;
	assign o_enum_speed = st.speed;
	// Drop strobe tells the receive path to discard the packet
	assign o_iso_drop = periph && i_evt.iso_out_rx && i_evt.rx_room_short;
	// Masked flags still latch; only the request line is gated
	assign o_irq = |(sts & st.mask);

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_b);

	sequence s_onak_set;
		i_evt.set_out_nak_all && !i_evt.clear_out_nak_all && !i_soft_rst;
	endsequence

	sequence s_onak_hold;
		!i_evt.clear_out_nak_all && !i_soft_rst;
	endsequence

	sequence s_frame_end_iso;
		periph && i_evt.periodic_frame_end && i_evt.iso_out_pending && !i_soft_rst;
	endsequence

	property p_hc_summary;
		o_status[`UCI_B_HC] == (i_host_mode && i_lvl.host_channel_any);
	endproperty
	a_hc_summary: assert property (p_hc_summary)
		else $error("host channel summary wrong");

	property p_oep_drop;
		$fell(i_lvl.out_endpoint_any) && periph && $past(periph) |-> !o_status[`UCI_B_OEP];
	endproperty
	a_oep_drop: assert property (p_oep_drop)
		else $error("out endpoint summary lingers");

	property p_fetch;
		periph && i_dma_mode && i_evt.fetch_stall && !i_soft_rst |=> o_status[`UCI_B_FETCH];
	endproperty
	a_fetch: assert property (p_fetch)
		else $error("fetch suspend not flagged");

	property p_iso_out_frame;
		s_frame_end_iso |=> o_status[`UCI_B_PINC] && o_status[`UCI_B_PERIODIC_FRAME_END];
	endproperty
	a_iso_out_frame: assert property (p_iso_out_frame)
		else $error("iso out incomplete not with frame end");

	property p_onak;
		s_onak_set ##1 s_onak_hold |=> o_status[`UCI_B_ONAK];
	endproperty
	a_onak: assert property (p_onak)
		else $error("out nak effective late");

	property p_nptx;
		o_status[`UCI_B_NPTX] == (i_host_mode && i_lvl.nptx_queue_free &&
			(i_tx_empty_level_select ? i_lvl.nptx_all_empty : i_lvl.nptx_half_empty));
	endproperty
	a_nptx: assert property (p_nptx)
		else $error("nonperiodic tx empty wrong");

	property p_wrong_mode_access;
		i_evt.host_reg_access && periph && !i_soft_rst |=> o_status[`UCI_B_WRONG_MODE_ACCESS];
	endproperty
	a_wrong_mode_access: assert property (p_wrong_mode_access)
		else $error("mode mismatch not flagged");

	property p_sof_clear;
		wr_sts && i_reg_wdata[`UCI_B_SOF] && !i_evt.sof_sent && !i_evt.sof_rcvd
			|=> !o_status[`UCI_B_SOF];
	endproperty
	a_sof_clear: assert property (p_sof_clear)
		else $error("write one did not clear");

	property p_keep_zero;
		wr_sts && !i_reg_wdata[`UCI_B_RST] && o_status[`UCI_B_RST] && !i_soft_rst
			|=> o_status[`UCI_B_RST];
	endproperty
	a_keep_zero: assert property (p_keep_zero)
		else $error("write zero cleared a flag");

	property p_irq;
		o_status[`UCI_B_RST] && !st.mask[`UCI_B_RST] && ((sts & st.mask) == '0) |-> !o_irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("masked flag raised interrupt");

	property p_suspend;
		idle_hit && periph && !i_soft_rst |=> o_status[`UCI_B_SUSP] && o_status[`UCI_B_EARLY_IDLE_SEEN];
	endproperty
	a_suspend: assert property (p_suspend)
		else $error("suspend flags missing");

	property p_role;
		o_status[`UCI_B_ROLE] == i_host_mode;
	endproperty
	a_role: assert property (p_role)
		else $error("role bit wrong");

	sequence s_inak_set;
		i_evt.set_in_nak_all && !i_evt.clear_in_nak_all && !i_soft_rst;
	endsequence

	sequence s_inak_hold;
		!i_evt.clear_in_nak_all && !i_soft_rst;
	endsequence

	property p_port_summary;
		o_status[`UCI_B_PORT] == (i_host_mode && i_lvl.host_port_any);
	endproperty
	a_port_summary: assert property (p_port_summary)
		else $error("host port summary wrong");

	property p_iep_summary;
		o_status[`UCI_B_IEP] == (periph && i_lvl.in_endpoint_any);
	endproperty
	a_iep_summary: assert property (p_iep_summary)
		else $error("in endpoint summary wrong");

	property p_otg_summary;
		o_status[`UCI_B_OTG] == i_lvl.dual_role_any;
	endproperty
	a_otg_summary: assert property (p_otg_summary)
		else $error("dual role summary wrong");

	property p_rx_pending;
		o_status[`UCI_B_RXP] == i_lvl.rx_packet_pending;
	endproperty
	a_rx_pending: assert property (p_rx_pending)
		else $error("receive pending wrong");

	property p_pinc_host;
		i_host_mode && i_evt.periodic_incomplete_host && !i_soft_rst |=> o_status[`UCI_B_PINC];
	endproperty
	a_pinc_host: assert property (p_pinc_host)
		else $error("incomplete periodic not flagged");

	property p_iso_in_frame;
		periph && i_evt.periodic_frame_end && i_evt.iso_in_pending && !i_soft_rst
			|=> o_status[`UCI_B_IISO] && o_status[`UCI_B_PERIODIC_FRAME_END];
	endproperty
	a_iso_in_frame: assert property (p_iso_in_frame)
		else $error("iso in incomplete not with frame end");

	property p_drop;
		o_iso_drop && !i_soft_rst |=> o_status[`UCI_B_DROP];
	endproperty
	a_drop: assert property (p_drop)
		else $error("dropped packet not flagged");

	property p_enum;
		periph && i_evt.speed_enum_done && !i_soft_rst
			|=> o_status[`UCI_B_ENUM] && (o_enum_speed == $past(i_enum_speed));
	endproperty
	a_enum: assert property (p_enum)
		else $error("enumeration done or speed wrong");

	property p_bus_reset;
		periph && i_evt.bus_reset_seen && !i_soft_rst |=> o_status[`UCI_B_RST];
	endproperty
	a_bus_reset: assert property (p_bus_reset)
		else $error("bus reset not flagged");

	property p_inak;
		s_inak_set ##1 s_inak_hold |=> o_status[`UCI_B_INAK];
	endproperty
	a_inak: assert property (p_inak)
		else $error("in nak effective late");

	property p_sof_low_speed;
		periph && !i_fs_mode && !o_status[`UCI_B_SOF] |=> !o_status[`UCI_B_SOF];
	endproperty
	a_sof_low_speed: assert property (p_sof_low_speed)
		else $error("start of frame flagged below full speed");

	property p_wrong_mode_access_host;
		i_evt.periph_reg_access && i_host_mode && !i_soft_rst |=> o_status[`UCI_B_WRONG_MODE_ACCESS];
	endproperty
	a_wrong_mode_access_host: assert property (p_wrong_mode_access_host)
		else $error("host mode mismatch not flagged");

	property p_irq_set;
		o_status[`UCI_B_RST] && st.mask[`UCI_B_RST] |-> o_irq;
	endproperty
	a_irq_set: assert property (p_irq_set)
		else $error("unmasked flag gave no interrupt");

	property p_idle_host;
		i_host_mode |=> !o_suspended;
	endproperty
	a_idle_host: assert property (p_idle_host)
		else $error("suspended while in host mode");
endmodule

// file: logic/uci_defs.svh
// Offsets, field positions, masks and timing counts of the core interrupt status block
//------------------------------------------------------------
//------------------------------------------------------------
`ifndef UCI_DEFS_SVH
`define UCI_DEFS_SVH

//------------------------------------------------------------
// Register map
//------------------------------------------------------------
`define UCI_ADDR_W 12
`define UCI_STS_OFS 12'h014
`define UCI_MSK_OFS 12'h018
`define UCI_STS_W1C 32'h0070fc0a
`define UCI_MSK_WR 32'hf77efcfe

//------------------------------------------------------------
// Status bit positions
//------------------------------------------------------------
`define UCI_B_HC 25
`define UCI_B_PORT 24
`define UCI_B_FETCH 22
`define UCI_B_PINC 21
`define UCI_B_IISO 20
`define UCI_B_OEP 19
`define UCI_B_IEP 18
`define UCI_B_PERIODIC_FRAME_END 15
`define UCI_B_DROP 14
`define UCI_B_ENUM 13
`define UCI_B_RST 12
`define UCI_B_SUSP 11
`define UCI_B_EARLY_IDLE_SEEN 10
`define UCI_B_ONAK 7
`define UCI_B_INAK 6
`define UCI_B_NPTX 5
`define UCI_B_RXP 4
`define UCI_B_SOF 3
`define UCI_B_OTG 2
`define UCI_B_WRONG_MODE_ACCESS 1
`define UCI_B_ROLE 0

//------------------------------------------------------------
// Timing
//------------------------------------------------------------
`define UCI_CLK_KHZ 25000
`define UCI_IDLE_MS 3
`define UCI_IDLE_CYC (`UCI_IDLE_MS * `UCI_CLK_KHZ)
`define UCI_IDLE_CW 17

`endif

// file: logic/uci_pkg.sv
// Types shared by the core interrupt status block
`include "uci_defs.svh"
package uci_pkg;

	//------------------------------------------------------------
	// One-cycle event strobes from the core
	//------------------------------------------------------------
	typedef struct packed {
		logic fetch_stall;
		logic periodic_incomplete_host;
		logic periodic_frame_end;
		logic iso_out_pending;
		logic iso_in_pending;
		logic iso_out_rx;
		logic rx_room_short;
		logic speed_enum_done;
		logic bus_reset_seen;
		logic sof_sent;
		logic sof_rcvd;
		logic set_out_nak_all;
		logic clear_out_nak_all;
		logic set_in_nak_all;
		logic clear_in_nak_all;
		logic host_reg_access;
		logic periph_reg_access;
	} uci_evt_s;

	//------------------------------------------------------------
	// Levels from the summarised sources
	//------------------------------------------------------------
	typedef struct packed {
		logic host_channel_any;
		logic host_port_any;
		logic out_endpoint_any;
		logic in_endpoint_any;
		logic dual_role_any;
		logic rx_packet_pending;
		logic nptx_half_empty;
		logic nptx_all_empty;
		logic nptx_queue_free;
	} uci_lvl_s;

	typedef struct packed {
		logic [31:0] flags;
		logic [31:0] mask;
		logic [31:0] rdata;
		logic rvalid;
		logic onak_req;
		logic inak_req;
		logic [1:0] speed;
	} uci_state_s;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic [`UCI_IDLE_CW-1:0] cnt;
		logic hit;
		logic susp;
	} uci_tmr_s;

endpackage

// file: logic/uci_idle_timer.sv
// Line idle timer: synchronised activity, 3 ms idle detection and suspended state
`timescale 1ns/1ps
`include "uci_defs.svh"
module uci_idle_timer #(
	parameter int IDLE_CYC = `UCI_IDLE_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_enable,
	input wire logic i_line_active,
	output logic o_idle_hit,
	output logic o_suspended
);
	uci_pkg::uci_tmr_s st;
	uci_pkg::uci_tmr_s next_st;
	localparam logic [`UCI_IDLE_CW-1:0] LAST = `UCI_IDLE_CW'(IDLE_CYC - 1);

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.sync1 = i_line_active;
		next_st.sync2 = st.sync1;
		next_st.hit = 1'b0;
		// Any activity or leaving peripheral mode restarts the idle count
		if (st.sync2 || !i_enable) begin
			next_st.cnt = '0;
			next_st.susp = 1'b0;
		end else if (!st.susp) begin
			if (st.cnt == LAST) begin
				next_st.hit = 1'b1;
				next_st.susp = 1'b1;
			end else begin
				next_st.cnt = st.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_idle_hit = st.hit;
	assign o_suspended = st.susp;
endmodule

// file: tb/tb.sv
// Self-checking bench for the core interrupt status block
`timescale 1ns/1ps
`include "uci_defs.svh"
module tb;
	localparam int IDLE = 20;
	localparam logic [31:0] LM = 32'h030c0035;
	logic i_clk_sys = 0, i_rst_b = 0, i_soft_rst = 0, i_host_mode = 0, i_dma_mode = 0;
	logic i_fs_mode = 1, i_tx_empty_level_select = 0, i_line_active = 1;
	logic i_reg_rd = 0, i_reg_wr = 0, drop;
	logic [1:0] i_enum_speed = 0, o_enum_speed;
	logic [`UCI_ADDR_W-1:0] i_reg_addr = 0;
	logic [31:0] i_reg_wdata = 0, o_reg_rdata, o_status, x;
	uci_pkg::uci_evt_s i_evt = '0, e;
	uci_pkg::uci_lvl_s i_lvl = '0, l;
	logic o_reg_rvalid, o_iso_drop, o_suspended, o_irq, m;
	int failures = 0, n_compared = 0, seed = 32'ha967, cnt;

	uci_core_status #(.IDLE_CYC(IDLE)) dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
		.i_soft_rst(i_soft_rst), .i_host_mode(i_host_mode), .i_dma_mode(i_dma_mode),
		.i_fs_mode(i_fs_mode), .i_tx_empty_level_select(i_tx_empty_level_select),
		.i_line_active(i_line_active), .i_enum_speed(i_enum_speed), .i_evt(i_evt),
		.i_lvl(i_lvl), .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
		.o_status(o_status), .o_enum_speed(o_enum_speed), .o_iso_drop(o_iso_drop),
		.o_suspended(o_suspended), .o_irq(o_irq));

	initial begin
		forever #20 i_clk_sys = ~i_clk_sys;
	end

	//------------------------------------------------------------
	// Bus cycles and comparison
	//------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("failures=%0d n_compared=%0d", failures, n_compared);
		if (failures == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Drop pulse is combinational, so it is caught while the strobe is up
	task automatic pulse(input uci_pkg::uci_evt_s ev);
		@(posedge i_clk_sys);
		i_evt <= ev;
		#1 drop = o_iso_drop;
		@(posedge i_clk_sys);
		i_evt <= '0;
		#1;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_reg_wr <= 1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk_sys);
		i_reg_wr <= 0;
		#1;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge i_clk_sys);
		i_reg_rd <= 1;
		i_reg_addr <= a;
		@(posedge i_clk_sys);
		i_reg_rd <= 0;
		#1;
		chk({31'h0, o_reg_rvalid}, 32'h1);
		chk(o_reg_rdata, exp);
	endtask
	function automatic logic [31:0] exp_lvl(input logic h, input uci_pkg::uci_lvl_s v,
		input logic s);
		logic [31:0] r;
		r = '0;
		r[25] = h & v.host_channel_any;
		r[24] = h & v.host_port_any;
		r[19] = ~h & v.out_endpoint_any;
		r[18] = ~h & v.in_endpoint_any;
		r[4] = v.rx_packet_pending;
		r[2] = v.dual_role_any;
		r[5] = h & v.nptx_queue_free & (s ? v.nptx_all_empty : v.nptx_half_empty);
		r[0] = h;
		return r;
	endfunction

	initial begin
		#400000;
		failures++;
		final_report();
	end

	//------------------------------------------------------------
	// Main sequence
	//------------------------------------------------------------
	initial begin
		repeat (12) @(posedge i_clk_sys);
		i_rst_b <= 1;
		rd(`UCI_STS_OFS, 32'h0);
		wr(`UCI_MSK_OFS, 32'hffffffff);
		rd(`UCI_MSK_OFS, `UCI_MSK_WR);
		wr(12'h01c, 32'hffffffff);
		rd(12'h01c, 32'h0);
		wr(`UCI_MSK_OFS, 32'h0);
		// Random levels in both roles; summaries of the other role must stay low
		repeat (60) begin
			x = $random(seed);
			m = x[0];
			l = x[9:1];
			@(posedge i_clk_sys);
			i_host_mode <= m;
			i_lvl <= l;
			i_tx_empty_level_select <= x[10];
			#1 chk(o_status & LM, exp_lvl(m, l, x[10]));
		end
		@(posedge i_clk_sys);
		i_lvl <= '0;
		// Sticky events: refused in the wrong role (fetch stall: refused with DMA off), set, kept by zero, cleared by one
		for (int k = 0; k < 11; k++) begin
			e = '0;
			m = 0;
			case (k)
				0: begin e.fetch_stall = 1; x = 32'h1 << 22; end
				1: begin e.periodic_incomplete_host = 1; m = 1; x = 32'h1 << 21; end
				2: begin e.periodic_frame_end = 1; e.iso_out_pending = 1; x = 32'h208000; end
				3: begin e.periodic_frame_end = 1; e.iso_in_pending = 1; x = 32'h108000; end
				4: begin e.iso_out_rx = 1; e.rx_room_short = 1; x = 32'h1 << 14; end
				5: begin e.speed_enum_done = 1; x = 32'h1 << 13; end
				6: begin e.bus_reset_seen = 1; x = 32'h1 << 12; end
				7: begin e.sof_sent = 1; m = 1; x = 32'h8; end
				8: begin e.sof_rcvd = 1; x = 32'h8; end
				9: begin e.host_reg_access = 1; x = 32'h2; end
				default: begin e.periph_reg_access = 1; m = 1; x = 32'h2; end
			endcase
			@(posedge i_clk_sys);
			i_host_mode <= (k == 0) ? m : ~m;
			i_dma_mode <= (k != 0);
			pulse(e);
			chk(o_status & x, 32'h0);
			i_host_mode <= m;
			i_dma_mode <= 1;
			i_enum_speed <= 2'($random(seed));
			pulse(e);
			chk(o_status & x, x);
			chk({31'h0, drop}, {31'h0, k == 4});
			if (k == 5) chk({30'h0, o_enum_speed}, {30'h0, i_enum_speed});
			chk({31'h0, o_irq}, 32'h0);
			wr(`UCI_MSK_OFS, x);
			chk({31'h0, o_irq}, 32'h1);
			wr(`UCI_MSK_OFS, 32'h0);
			wr(`UCI_STS_OFS, ~x);
			rd(`UCI_STS_OFS, x | {31'h0, m});
			wr(`UCI_STS_OFS, x);
			chk(o_status & x, 32'h0);
		end
		// Peripheral start of frame is only reported at full speed
		@(posedge i_clk_sys);
		i_host_mode <= 0;
		i_fs_mode <= 0;
		e = '0;
		e.sof_rcvd = 1;
		pulse(e);
		chk(o_status & 32'h8, 32'h0);
		i_fs_mode <= 1;
		// Global NAK requests: flag two cycles after the request, dropped by clear
		i_host_mode <= 0;
		for (int j = 0; j < 2; j++) begin
			e = '0;
			x = (j == 0) ? 32'h80 : 32'h40;
			e.set_out_nak_all = (j == 0);
			e.set_in_nak_all = (j == 1);
			pulse(e);
			@(posedge i_clk_sys);
			#1 chk(o_status & x, x);
			wr(`UCI_STS_OFS, x);
			chk(o_status & x, x);
			e = '0;
			e.clear_out_nak_all = (j == 0);
			e.clear_in_nak_all = (j == 1);
			pulse(e);
			chk(o_status & x, 32'h0);
		end
		// Line idle: nothing while active, both flags after the idle span
		repeat (2 * IDLE) @(posedge i_clk_sys);
		#1 chk(o_status & 32'hc00, 32'h0);
		@(posedge i_clk_sys);
		i_line_active <= 0;
		cnt = 0;
		while (o_suspended !== 1'b1 && cnt < 3 * IDLE) begin
			@(posedge i_clk_sys);
			#1 cnt++;
		end
		chk({31'h0, cnt >= IDLE && cnt <= IDLE + 8}, 32'h1);
		// The flags latch one edge after the suspended state is entered
		@(posedge i_clk_sys);
		#1 chk(o_status & 32'hc00, 32'hc00);
		// Soft reset clears the sticky flags and the mask
		wr(`UCI_MSK_OFS, 32'hffffffff);
		@(posedge i_clk_sys);
		i_line_active <= 1;
		i_soft_rst <= 1;
		@(posedge i_clk_sys);
		i_soft_rst <= 0;
		#1 chk(o_status & `UCI_STS_W1C, 32'h0);
		rd(`UCI_MSK_OFS, 32'h0);
		final_report();
	end
endmodule
